//--- umd_params.svh
// Constants of the modem-status, divisor and flow-control register block.
// Assumes inclusion by bare name; definitions only.
`ifndef UMD_PARAMS_SVH
`define UMD_PARAMS_SVH

// Register word indices on the Avalon-MM slave
`define UMD_IDX_LINE_STATUS   4'h0
`define UMD_IDX_MODEM_STATUS  4'h1
`define UMD_IDX_SCRATCH_PAD   4'h2
`define UMD_IDX_DIV_LOW       4'h3
`define UMD_IDX_DIV_HIGH      4'h4
`define UMD_IDX_DIV_FRACTION  4'h5
`define UMD_IDX_ENH_FEATURE   4'h6
`define UMD_IDX_INT_ENABLE    4'h7
`define UMD_IDX_MODEM_CONTROL 4'h8
`define UMD_IDX_FIFO_CONTROL  4'h9
`define UMD_IDX_INT_STATUS    4'hA
`define UMD_IDX_RESUME_ONE    4'hB
`define UMD_IDX_RESUME_TWO    4'hC
`define UMD_IDX_PAUSE_ONE     4'hD
`define UMD_IDX_PAUSE_TWO     4'hE

// Reset values
`define UMD_RST_SCRATCH       8'hFF
`define UMD_RST_DIV_LOW       8'h01
`define UMD_RST_ZERO          8'h00

// Field positions
`define UMD_EFR_ENH_BIT       4
`define UMD_EFR_SPECIAL_BIT   5
`define UMD_EFR_AUTOCTS_BIT   7
`define UMD_IER_MODEM_BIT     3
`define UMD_IER_FLOW_BIT      5
`define UMD_MCR_LOOP_BIT      4
`define UMD_MCR_XONANY_BIT    5
`define UMD_MCR_IRDA_BIT      6
`define UMD_MCR_PRESCALE_BIT  7
`define UMD_ISR_FLOW_BIT      4

// Write masks of the bits that only change while enhanced writes are on
`define UMD_MASK_IER_ENH      8'hF0
`define UMD_MASK_FCR_ENH      8'h30
`define UMD_MASK_MCR_ENH      8'hE0
`define UMD_MASK_ISR_ENH      8'h30
`define UMD_MASK_ALL          8'hFF

// Receive error counter width (holds 0..64 tagged bytes)
`define UMD_ERRCNT_W          7

`endif

//--- umd_pkg.sv
// Types shared by the modem-status, divisor and flow-control register block.
// Assumes umd_params.svh is on the include path.
`include "umd_params.svh"

package umd_pkg;

  // Oversampling rate presented to the baud generator
  typedef enum logic [1:0]
  {
    UMD_RATE_16X = 2'b00,
    UMD_RATE_8X  = 2'b01,
    UMD_RATE_4X  = 2'b10
  } umd_rate_t;

  // Baud generator and line configuration
  typedef struct packed {
    logic [15:0] divInt;
    logic [3:0]  divFrac;
    umd_rate_t   rate;
    logic        prescaleBy4;
    logic        irdaEn;
    logic        loopback;
  } umd_line_cfg_t;

  // Transmit software flow-control configuration
  typedef struct packed {
    logic [1:0] txSel;
    logic [7:0] resumeOne;
    logic [7:0] resumeTwo;
    logic [7:0] pauseOne;
    logic [7:0] pauseTwo;
  } umd_flow_cfg_t;

  // Whole state of the register block
  typedef struct packed {
    logic                      busy;
    logic [7:0]                rdata;
    logic [3:0]                pinMeta;
    logic [3:0]                pinSync;
    logic                      primed;
    logic [3:0]                prevStat;
    logic [3:0]                delta;
    logic [7:0]                scratch;
    logic [7:0]                divLow;
    logic [7:0]                divHigh;
    logic [7:0]                divFrac;
    logic [7:0]                enhFeature;
    logic [7:0]                intEnable;
    logic [7:0]                modemControl;
    logic [7:0]                fifoControl;
    logic [7:0]                intStatus;
    logic [7:0]                resumeOne;
    logic [7:0]                resumeTwo;
    logic [7:0]                pauseOne;
    logic [7:0]                pauseTwo;
    logic [`UMD_ERRCNT_W-1:0]  errCnt;
    logic                      seqResume;
    logic                      seqPause;
    logic                      txPaused;
  } umd_state_t;

endpackage

//--- umd_regs.sv
// Per-channel UART register block: line error summary, modem status with
// loopback, scratch pad, fractional baud divisor, enhanced feature control
// and software flow-control character matching.
// Assumes a receive datapath that reports FIFO pushes/pops of tagged bytes
// and offers each received character once, and a transmitter that obeys
// txHold at character boundaries.
//
// Overview of operation
// - Error summary bit set while any stored receive byte carries an error tag.
// - Clear-to-send, data-set-ready, carrier-detect deltas set on any change.
// - Ring delta set only when the ring pin goes low to high.
// - Modem interrupt when any delta set and its enable bit is one.
// - Auto clear-to-send: high pin holds transmitter after current character.
// - Clear-to-send status is inverted pin, or request-to-send bit in loopback.
// - Data-set-ready status is inverted pin, or terminal-ready bit in loopback.
// - Ring status is inverted pin, or modem control bit 2 in loopback.
// - Carrier status is inverted pin, or modem control bit 3 in loopback.
// - Eight-bit scratch pad, read/write, resets to all ones.
// - Divisor is high and low bytes as integer plus fraction nibble over 16.
// - Fraction register writable only while enhanced-write bit is one.
// - Fraction bits 5:4 pick 16X, 8X, or 4X when bit 5 set.
// - Feature bits 3:2 pick transmit flow characters: none, first, second, both.
// - Feature bits 1:0 pick receive comparison, either pair or sequence for 11.
// - Dual mode treats the two characters as one back-to-back sequence.
// - Enhanced-write bit gates the enhanced bits; clearing it freezes them.
// - Reset clears all enhanced bits including the fraction register.
// - Special detect matches second pause character, stores it, flags status bit 4.
// - With second-pair compare, a special match is dropped and raises both events.
// - Modem control bit 4 selects internal loopback; clear by default.
`timescale 1ns/100ps

module umd_regs
  import umd_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  // Avalon-MM slave, word addressed
  input  wire logic [3:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  // Modem input pins, active low, asynchronous
  input  wire logic          ctsN,
  input  wire logic          dsrN,
  input  wire logic          ring_indicator_n,
  input  wire logic          carrier_detect_n,
  // Modem output pins, active low
  output logic               rtsN,
  output logic               dtrN,
  // Receive datapath status
  input  wire logic [6:0]    lineStatLow,
  input  wire logic          rxPushErr,
  input  wire logic          rxPopErr,
  input  wire logic          rxCharValid,
  input  wire logic [7:0]    rxChar,
  output logic               rxStore,
  // Transmit control and flow events
  output logic               txHold,
  output logic               pauseEvt,
  output logic               specialEvt,
  // Interrupt requests and configuration
  output logic               modemIrq,
  output logic               flowIrq,
  output umd_line_cfg_t      lineCfg,
  output umd_flow_cfg_t      flowCfg,
  output logic [7:0]         fifoCtrl
);

  umd_state_t r;
  umd_state_t next_r;

  // Replace only the bits under mask when enabled
  function automatic logic [7:0] gatedWrite(input logic [7:0] oldV, input logic [7:0] newV,
                                            input logic [7:0] mask, input logic en);
    gatedWrite = en ? ((oldV & ~mask) | (newV & mask)) : oldV;
  endfunction

  // Oversampling decode; bit 5 wins over bit 4
  function automatic umd_rate_t rateOf(input logic [7:0] frac);
    if (frac[5])
      rateOf = UMD_RATE_4X;
    else if (frac[4])
      rateOf = UMD_RATE_8X;
    else
      rateOf = UMD_RATE_16X;
  endfunction

  logic       acc;
  logic       done;
  logic       wrDone;
  logic       enhOn;
  logic       loopOn;
  logic [3:0] stat;
  logic [3:0] chg;
  logic [7:0] wd;
  logic [7:0] rdVal;
  logic       m1on, m2on, m1off, m2off;
  logic       hitOn, hitOff;
  logic       flowChar;
  logic       seqMode;
  logic [1:0] rxSel;
  logic [1:0] txSel;
  logic       errUp, errDown;

  // Bus handshake: first cycle registers read data, second completes
  assign acc             = avs_read | avs_write;
  assign avs_waitrequest = acc & ~r.busy;
  assign done            = acc & r.busy;
  assign wrDone          = done & avs_write;
  assign avs_readdata    = {24'h000000, r.rdata};
  assign wd              = avs_writedata[7:0];

  // Field decode
  assign enhOn  = r.enhFeature[`UMD_EFR_ENH_BIT];
  assign loopOn = r.modemControl[`UMD_MCR_LOOP_BIT];
  assign rxSel  = r.enhFeature[1:0];
  assign txSel  = r.enhFeature[3:2];

  // Modem status source: inverted pins, or modem control bits in loopback
  always_comb
  begin
    if (loopOn)
    begin
      stat[0] = r.modemControl[1];
      stat[1] = r.modemControl[0];
      stat[2] = r.modemControl[2];
      stat[3] = r.modemControl[3];
    end
    else
    begin
      stat = ~r.pinSync;
    end
  end

  // Change detection; ring only on pin low-to-high, i.e. status falling
  always_comb
  begin
    chg = 4'h0;
    if (r.primed)
    begin
      chg[0] = stat[0] ^ r.prevStat[0];
      chg[1] = stat[1] ^ r.prevStat[1];
      chg[2] = r.prevStat[2] & ~stat[2];
      chg[3] = stat[3] ^ r.prevStat[3];
    end
  end

  // Flow-control character compares
  assign m1on  = rxChar == r.resumeOne;
  assign m2on  = rxChar == r.resumeTwo;
  assign m1off = rxChar == r.pauseOne;
  assign m2off = rxChar == r.pauseTwo;
  // Transmit select 11 or 00 turns receive 11 into sequence matching
  assign seqMode = (rxSel == 2'b11) && (txSel[1] == txSel[0]);

  always_comb
  begin
    hitOn    = 1'b0;
    hitOff   = 1'b0;
    flowChar = 1'b0;
    case (rxSel)
      2'b10:
      begin
        hitOn  = m1on;
        hitOff = m1off;
      end
      2'b01:
      begin
        hitOn  = m2on;
        hitOff = m2off;
      end
      2'b11:
      begin
        if (seqMode)
        begin
          hitOn  = r.seqResume & m2on;
          hitOff = r.seqPause & m2off;
        end
        else
        begin
          hitOn  = m1on | m2on;
          hitOff = m1off | m2off;
        end
      end
      default:
      begin
        hitOn  = 1'b0;
        hitOff = 1'b0;
      end
    endcase
    // Single-character flow chars are consumed; sequence chars pass on
    if (!seqMode)
      flowChar = hitOn | hitOff;
  end

  // Character events; a special match in second-pair mode is a flow char
  assign specialEvt = rxCharValid & r.enhFeature[`UMD_EFR_SPECIAL_BIT] & m2off;
  assign pauseEvt   = rxCharValid & hitOff;
  assign rxStore    = rxCharValid & ~flowChar;

  // Error tag bookkeeping of the receive FIFO
  assign errUp   = rxPushErr & ~rxPopErr;
  assign errDown = rxPopErr & ~rxPushErr & (r.errCnt != '0);

  // Read mux, sampled in the first cycle of a read
  always_comb
  begin
    rdVal = 8'h00;
    case (avs_address)
      `UMD_IDX_LINE_STATUS:   rdVal = {(r.errCnt != '0), lineStatLow};
      `UMD_IDX_MODEM_STATUS:  rdVal = {stat, r.delta};
      `UMD_IDX_SCRATCH_PAD:   rdVal = r.scratch;
      `UMD_IDX_DIV_LOW:       rdVal = r.divLow;
      `UMD_IDX_DIV_HIGH:      rdVal = r.divHigh;
      `UMD_IDX_DIV_FRACTION:  rdVal = r.divFrac;
      `UMD_IDX_ENH_FEATURE:   rdVal = r.enhFeature;
      `UMD_IDX_INT_ENABLE:    rdVal = r.intEnable;
      `UMD_IDX_MODEM_CONTROL: rdVal = r.modemControl;
      `UMD_IDX_FIFO_CONTROL:  rdVal = r.fifoControl;
      `UMD_IDX_INT_STATUS:    rdVal = r.intStatus;
      `UMD_IDX_RESUME_ONE:    rdVal = r.resumeOne;
      `UMD_IDX_RESUME_TWO:    rdVal = r.resumeTwo;
      `UMD_IDX_PAUSE_ONE:     rdVal = r.pauseOne;
      `UMD_IDX_PAUSE_TWO:     rdVal = r.pauseTwo;
      default:                rdVal = 8'h00;
    endcase
  end

  // Next-state of the whole block
  always_comb
  begin
    next_r = r;
    // Bus sequencing
    next_r.busy = acc & ~r.busy;
    if (avs_read & ~r.busy)
      next_r.rdata = rdVal;

    // Pin synchroniser; only the second stage is looked at
    next_r.pinMeta  = {carrier_detect_n, ring_indicator_n, dsrN, ctsN};
    next_r.pinSync  = r.pinMeta;
    // No false delta at reset
    next_r.primed   = 1'b1;
    next_r.prevStat = stat;

    // Deltas: clear only what the read reported, new changes win
    next_r.delta = r.delta;
    if (done && avs_read && avs_address == `UMD_IDX_MODEM_STATUS)
      next_r.delta = r.delta & ~r.rdata[3:0];
    next_r.delta = next_r.delta | chg;

    // Receive error count
    if (errUp)
      next_r.errCnt = r.errCnt + `UMD_ERRCNT_W'(1);
    else if (errDown)
      next_r.errCnt = r.errCnt - `UMD_ERRCNT_W'(1);

    // Flow control state, hardware events
    next_r.seqResume = r.seqResume;
    next_r.seqPause  = r.seqPause;
    if (rxCharValid)
    begin
      next_r.seqResume = seqMode & m1on;
      next_r.seqPause  = seqMode & m1off;
      if (hitOff)
        next_r.txPaused = 1'b1;
      else if (hitOn || r.modemControl[`UMD_MCR_XONANY_BIT])
        next_r.txPaused = 1'b0;
    end
    // Flow off drops a stale pause
    if (rxSel == 2'b00)
      next_r.txPaused = 1'b0;

    // Register writes on the completing edge
    if (wrDone)
    begin
      case (avs_address)
        `UMD_IDX_SCRATCH_PAD:   next_r.scratch = wd;
        `UMD_IDX_DIV_LOW:       next_r.divLow = wd;
        `UMD_IDX_DIV_HIGH:      next_r.divHigh = wd;
        `UMD_IDX_DIV_FRACTION:
          next_r.divFrac = gatedWrite(r.divFrac, wd, `UMD_MASK_ALL, enhOn);
        `UMD_IDX_ENH_FEATURE:   next_r.enhFeature = wd;
        `UMD_IDX_INT_ENABLE:
        begin
          next_r.intEnable = gatedWrite(r.intEnable, wd, ~`UMD_MASK_IER_ENH, 1'b1);
          next_r.intEnable = gatedWrite(next_r.intEnable, wd, `UMD_MASK_IER_ENH, enhOn);
        end
        `UMD_IDX_MODEM_CONTROL:
        begin
          next_r.modemControl = gatedWrite(r.modemControl, wd, ~`UMD_MASK_MCR_ENH, 1'b1);
          next_r.modemControl = gatedWrite(next_r.modemControl, wd, `UMD_MASK_MCR_ENH,
                                           enhOn);
        end
        `UMD_IDX_FIFO_CONTROL:
        begin
          next_r.fifoControl = gatedWrite(r.fifoControl, wd, ~`UMD_MASK_FCR_ENH, 1'b1);
          next_r.fifoControl = gatedWrite(next_r.fifoControl, wd, `UMD_MASK_FCR_ENH,
                                          enhOn);
        end
        `UMD_IDX_INT_STATUS:
          next_r.intStatus = gatedWrite(r.intStatus, wd, `UMD_MASK_ISR_ENH, enhOn);
        `UMD_IDX_RESUME_ONE:    next_r.resumeOne = wd;
        `UMD_IDX_RESUME_TWO:    next_r.resumeTwo = wd;
        `UMD_IDX_PAUSE_ONE:     next_r.pauseOne = wd;
        `UMD_IDX_PAUSE_TWO:     next_r.pauseTwo = wd;
        default:                next_r.scratch = r.scratch;
      endcase
    end

    // Flow and special events set status bit 4 after any write: set wins
    if (specialEvt || pauseEvt)
      next_r.intStatus[`UMD_ISR_FLOW_BIT] = 1'b1;
  end

  // State register; reset puts the channel in legacy-compatible form
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      r              <= '0;
      r.scratch      <= `UMD_RST_SCRATCH;
      r.divLow       <= `UMD_RST_DIV_LOW;
      r.divHigh      <= `UMD_RST_ZERO;
      r.divFrac      <= `UMD_RST_ZERO;
      r.pinMeta      <= 4'hF;
      r.pinSync      <= 4'hF;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Interrupt requests
  assign modemIrq = (|r.delta) & r.intEnable[`UMD_IER_MODEM_BIT];
  assign flowIrq  = r.intStatus[`UMD_ISR_FLOW_BIT] & r.intEnable[`UMD_IER_FLOW_BIT];

  // Transmitter hold: auto clear-to-send or software pause
  assign txHold = (r.enhFeature[`UMD_EFR_AUTOCTS_BIT] & ~stat[0]) | r.txPaused;

  // Modem outputs go inactive while looped back internally
  assign rtsN = ~(r.modemControl[1] & ~loopOn);
  assign dtrN = ~(r.modemControl[0] & ~loopOn);

  // Configuration outputs, all from registers
  always_comb
  begin
    lineCfg.divInt      = {r.divHigh, r.divLow};
    lineCfg.divFrac     = r.divFrac[3:0];
    lineCfg.rate        = rateOf(r.divFrac);
    lineCfg.prescaleBy4 = r.modemControl[`UMD_MCR_PRESCALE_BIT];
    lineCfg.irdaEn      = r.modemControl[`UMD_MCR_IRDA_BIT];
    lineCfg.loopback    = loopOn;
    flowCfg.txSel       = txSel;
    flowCfg.resumeOne   = r.resumeOne;
    flowCfg.resumeTwo   = r.resumeTwo;
    flowCfg.pauseOne    = r.pauseOne;
    flowCfg.pauseTwo    = r.pauseTwo;
  end

  // Plain register out
  assign fifoCtrl = r.fifoControl;

endmodule

//--- umd_regs_properties.sv
// Concurrent checks on the register block ports: handshake, divisor,
// loopback, modem interrupt and flow-control relations.
// Assumes one clock domain and control registers written over the bus.
`timescale 1ns/100ps
module umd_regs_checker
  import umd_pkg::*;
(
  // Clock, reset and bus
  input wire logic          clk_sys,
  input wire logic          nrst,
  input wire logic [3:0]    avs_address,
  input wire logic          avs_read,
  input wire logic          avs_write,
  input wire logic [31:0]   avs_writedata,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  // Line side, events and configuration
  input wire logic          rtsN,
  input wire logic          dtrN,
  input wire logic          rxCharValid,
  input wire logic [7:0]    rxChar,
  input wire logic          rxStore,
  input wire logic          txHold,
  input wire logic          pauseEvt,
  input wire logic          specialEvt,
  input wire logic          modemIrq,
  input wire umd_line_cfg_t lineCfg,
  input wire umd_flow_cfg_t flowCfg
);
  logic [7:0] efrSh;
  logic [7:0] mcrSh;
  logic [7:0] ierSh;
  logic       wrDone;
  logic       rdDone;
  logic       spMatch;

  // Completed transfers and special-character candidates
  assign wrDone = avs_write && !avs_waitrequest;
  assign rdDone = avs_read && !avs_waitrequest;
  assign spMatch = rxCharValid && efrSh[5] && rxChar == flowCfg.pauseTwo;

  // Shadows of ungated control bits, so no internal state is peeked at
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      efrSh <= 8'h00;
      mcrSh <= 8'h00;
      ierSh <= 8'h00;
    end
    else if (wrDone)
    begin
      if (avs_address == 4'h6)
        efrSh <= avs_writedata[7:0];
      if (avs_address == 4'h8)
        mcrSh <= avs_writedata[7:0];
      if (avs_address == 4'h7)
        ierSh <= avs_writedata[7:0];
    end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_wait_once: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  a_frac_gate: assert property (
    wrDone && avs_address == 4'h5 && !efrSh[4] |=> $stable(lineCfg.divFrac) && $stable(lineCfg.rate))
    else $error("fraction changed while enhanced writes off");
  a_frac_rate: assert property (
    wrDone && avs_address == 4'h5 && efrSh[4] |=> lineCfg.divFrac == $past(avs_writedata[3:0])
      && lineCfg.rate == ($past(avs_writedata[5]) ? UMD_RATE_4X
      : ($past(avs_writedata[4]) ? UMD_RATE_8X : UMD_RATE_16X)))
    else $error("fraction or sampling rate wrong after write");
  a_tx_select: assert property (
    wrDone && avs_address == 4'h6 |=> flowCfg.txSel == $past(avs_writedata[3:2]))
    else $error("transmit flow selection not taken");
  a_loop_pins: assert property (
    lineCfg.loopback == mcrSh[4] && rtsN == (mcrSh[4] || !mcrSh[1])
      && dtrN == (mcrSh[4] || !mcrSh[0]))
    else $error("loopback or modem outputs wrong");
  a_loop_status: assert property (
    rdDone && avs_address == 4'h1 && lineCfg.loopback && $past(lineCfg.loopback, 4)
      && $past(mcrSh, 4) == mcrSh |-> avs_readdata[7:4] == {mcrSh[3:2], mcrSh[0], mcrSh[1]})
    else $error("loopback status bits wrong");
  a_irq_delta: assert property (
    (rdDone && avs_address == 4'h1 && |avs_readdata[3:0] && ierSh[3] |-> modemIrq)
      and (modemIrq |-> ierSh[3]))
    else $error("modem interrupt disagrees with deltas");
  a_pause_hold: assert property (
    pauseEvt |=> txHold)
    else $error("pause match did not hold transmitter");
  a_special_drop: assert property (
    spMatch && efrSh[1:0] == 2'b01 |-> specialEvt && pauseEvt && !rxStore)
    else $error("special pause char mishandled");
  a_special_keep: assert property (
    spMatch && efrSh[3:0] == 4'h0 |-> specialEvt && rxStore)
    else $error("special char not stored or flagged");
endmodule

bind umd_regs umd_regs_checker i_chk (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .rtsN, .dtrN, .rxCharValid, .rxChar,
  .rxStore, .txHold, .pauseEvt, .specialEvt, .modemIrq, .lineCfg, .flowCfg);

//--- umd_peer_model.sv
// Remote modem and serial peer: drives the modem pins and offers
// received characters. Assumes its tasks are called from one process.
`timescale 1ns/100ps
module umd_peer_model
(
  // Clock
  input wire logic clk_sys,
  // Modem pins, active low
  output logic     ctsN,
  output logic     dsrN,
  output logic     ring_indicator_n,
  output logic     carrier_detect_n,
  // Received character strobe
  output logic     rxCharValid,
  output logic [7:0] rxChar
);
  // Idle line: pins inactive, nothing offered
  initial
  begin
    {carrier_detect_n, ring_indicator_n, dsrN, ctsN} = 4'hF;
    rxCharValid = 1'b0;
    rxChar = 8'h00;
  end

  // Pin order {cd, ri, dsr, cts}; changes land just after an edge
  task automatic set_pins(input logic [3:0] v);
    @(posedge clk_sys);
    {carrier_detect_n, ring_indicator_n, dsrN, ctsN} <= v;
  endtask

  // Optional delay first; afterwards the data shows a new pattern, not the old byte
  task automatic send_char(input logic [7:0] c, input int gap);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    rxCharValid <= 1'b1;
    rxChar <= c;
    @(posedge clk_sys);
    rxCharValid <= 1'b0;
    rxChar <= ~c;
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for the modem-status, divisor and flow-control block.
// Assumes umd_pkg, the peer model and the bound checker are compiled first.
`timescale 1ns/100ps
module testbench
  import umd_pkg::*;
;
  logic          clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]    avs_address;
  logic [31:0]   avs_writedata, avs_readdata;
  logic          ctsN, dsrN, ring_indicator_n, carrier_detect_n, rtsN, dtrN;
  logic [6:0]    lineStatLow;
  logic          rxPushErr, rxPopErr, rxCharValid, rxStore;
  logic [7:0]    rxChar, fifoCtrl, v, dl, dh, ch [4];
  logic          txHold, pauseEvt, specialEvt, modemIrq, flowIrq;
  umd_line_cfg_t lineCfg;
  umd_flow_cfg_t flowCfg;
  logic [15:0]   notes [$];
  logic [15:0]   nt;
  int            num_errors, checks_done, i;
  logic [7:0]    fr [4] = '{8'h05, 8'h1A, 8'h2C, 8'h3F};
  logic [7:0]    fe [6] = '{8'h0A, 8'h05, 8'h0B, 8'h0F, 8'h03, 8'h0A};
  int            fa [6] = '{2, 3, 3, 2, 2, 3};
  int            fb [6] = '{4, 4, 4, 3, 3, 4};
  logic          fh [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  umd_regs i_dut (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .ctsN, .dsrN, .ring_indicator_n, .carrier_detect_n,
    .rtsN, .dtrN, .lineStatLow, .rxPushErr, .rxPopErr, .rxCharValid, .rxChar, .rxStore,
    .txHold, .pauseEvt, .specialEvt, .modemIrq, .flowIrq, .lineCfg, .flowCfg, .fifoCtrl);
  umd_peer_model i_peer (.clk_sys, .ctsN, .dsrN, .ring_indicator_n, .carrier_detect_n,
    .rxCharValid, .rxChar);

  // 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Request held until waitrequest is sampled low; the watchdog ends a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  // Note the masked expectation; the monitor compares it when the read lands
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    notes.push_back({m, e});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic err(input logic p, input logic q);
    @(posedge clk_sys);
    rxPushErr <= p;
    rxPopErr <= q;
    @(posedge clk_sys);
    rxPushErr <= 1'b0;
    rxPopErr <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Read monitor: oldest note against the data of each completed read
  always @(posedge clk_sys)
    if (avs_read && avs_waitrequest === 1'b0)
    begin
      if (notes.size() == 0)
        chk("notes", 16'h1, 16'h0);
      else
      begin
        nt = notes.pop_front();
        chk("readdata", {8'h00, nt[7:0] & nt[15:8]}, {8'h00, avs_readdata[7:0] & nt[15:8]});
      end
    end

  // Watchdog, generous against the few hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    report_and_stop;
  end

  initial
  begin
    {avs_read, avs_write, rxPushErr, rxPopErr} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    lineStatLow = 7'h00;
    nrst = 1'b0;
    void'($urandom(89));
    tick(8);
    nrst <= 1'b1;
    // Reset values, unmapped index included
    rd(4'h2, 8'hFF, 8'hFF);
    rd(4'h3, 8'hFF, 8'h01);
    for (i = 0; i < 16; i++)
      if (i != 2 && i != 3)
        rd(i[3:0], 8'hFF, 8'h00);
    v = 8'($urandom);
    wr(4'h2, v);
    rd(4'h2, 8'hFF, v);
    $display("Test reset done");
    // Divisor: gated fraction, every sampling rate, freeze on clear
    wr(4'h5, 8'h2F);
    rd(4'h5, 8'hFF, 8'h00);
    wr(4'h6, 8'h10);
    for (i = 0; i < 4; i++)
    begin
      wr(4'h5, fr[i]);
      rd(4'h5, 8'hFF, fr[i]);
      chk("rate", fr[i][5] ? 2'b10 : {1'b0, fr[i][4]}, lineCfg.rate);
    end
    dl = 8'($urandom);
    dh = 8'($urandom);
    wr(4'h3, dl);
    wr(4'h4, dh);
    tick(1);
    chk("divInt", {dh, dl}, lineCfg.divInt);
    wr(4'h6, 8'h00);
    wr(4'h5, 8'h00);
    rd(4'h5, 8'hFF, 8'h3F);
    wr(4'h7, 8'hF8);
    rd(4'h7, 8'hFF, 8'h08);
    wr(4'h9, 8'h3F);
    tick(1);
    chk("fifoCtrl", 8'h0F, fifoCtrl);
    $display("Test divisor done");
    // Modem inputs: deltas, ring edge direction, clear on read, interrupt
    i_peer.set_pins(4'h0);
    tick(5);
    rd(4'h1, 8'hFF, 8'hFB);
    rd(4'h1, 8'hFF, 8'hF0);
    i_peer.set_pins(4'hF);
    tick(5);
    chk("modemIrq", 1'b1, modemIrq);
    rd(4'h1, 8'hFF, 8'h0F);
    tick(2);
    chk("modemIrq", 1'b0, modemIrq);
    wr(4'h6, 8'h80);
    tick(2);
    chk("txHold", 1'b1, txHold);
    i_peer.set_pins(4'hE);
    tick(5);
    chk("txHold", 1'b0, txHold);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h00);
    // Loopback substitution, then normal outputs
    wr(4'h8, 8'h15);
    tick(4);
    rd(4'h1, 8'hF0, 8'h60);
    wr(4'h8, 8'h1A);
    tick(4);
    rd(4'h1, 8'hF0, 8'h90);
    chk("rtsN", 1'b1, rtsN);
    wr(4'h8, 8'h03);
    tick(1);
    chk("rtsN", 1'b0, rtsN);
    wr(4'h8, 8'h00);
    $display("Test modem done");
    // Error summary: push, push, push with pop, pop
    lineStatLow <= 7'($urandom);
    err(1'b1, 1'b0);
    err(1'b1, 1'b0);
    err(1'b1, 1'b1);
    err(1'b0, 1'b1);
    rd(4'h0, 8'hFF, {1'b1, lineStatLow});
    err(1'b0, 1'b1);
    rd(4'h0, 8'hFF, {1'b0, lineStatLow});
    // Flow characters, then each selection from the table
    v = 8'($urandom);
    for (i = 0; i < 4; i++)
    begin
      ch[i] = v + 8'(i);
      wr(4'hB + 4'(i), ch[i]);
    end
    for (i = 0; i < 6; i++)
    begin
      wr(4'h6, 8'h00);
      wr(4'h6, fe[i]);
      i_peer.send_char(ch[fa[i]], i);
      if (fb[i] < 4)
        i_peer.send_char(ch[fb[i]], 0);
      tick(2);
      chk("txHold", fh[i], txHold);
      chk("txSel", fe[i][3:2], flowCfg.txSel);
    end
    i_peer.send_char(ch[2], 0);
    i_peer.send_char(ch[0], 3);
    tick(2);
    chk("txHold", 1'b0, txHold);
    // Special character: dropped with second pair, kept without flow
    wr(4'h6, 8'h00);
    wr(4'h6, 8'h10);
    wr(4'h7, 8'h20);
    wr(4'h6, 8'h31);
    i_peer.send_char(ch[3], 0);
    tick(2);
    chk("flowIrq", 1'b1, flowIrq);
    rd(4'hA, 8'h10, 8'h10);
    wr(4'h6, 8'h10);
    wr(4'hA, 8'h00);
    wr(4'h6, 8'h30);
    i_peer.send_char(ch[3], 0);
    rd(4'hA, 8'h10, 8'h10);
    $display("Test flow done");
    tick(3);
    report_and_stop;
  end
endmodule
